// ---- rtl/pllcf_pkg.sv ----
// Package with offsets, field layout and reset values of the loop configuration registers
package pllcf_pkg;
    localparam int PLLCF_AW = 8;
    localparam int PLLCF_DW = 16;

    // Register offsets
    localparam logic [7:0] PLLCF_LOOP_FILTER_OFS = 8'h1f;
    localparam logic [7:0] PLLCF_LOCK_DETECT_OFS = 8'h21;

    // Reset values of the whole words
    localparam logic [15:0] PLLCF_LOOP_FILTER_RST = 16'h1e72;
    localparam logic [15:0] PLLCF_LOCK_DETECT_RST = 16'h0007;

    // Loop-filter field layout
    localparam int PLLCF_RES_LSB = 5;
    localparam int PLLCF_RES_W = 4;
    localparam int PLLCF_PCAP_LSB = 0;
    localparam int PLLCF_PCAP_W = 5;

    // Lock-detect field layout
    localparam int PLLCF_DLY_LSB = 5;
    localparam int PLLCF_DLY_W = 2;
    localparam int PLLCF_WIN_LSB = 2;
    localparam int PLLCF_WIN_W = 3;
    localparam int PLLCF_WAIT_LSB = 0;
    localparam int PLLCF_WAIT_W = 2;
    localparam int PLLCF_LD_RSVD_LSB = 7;

    // Decoded settings
    localparam logic [3:0] PLLCF_DLY_SET0 = 4'h2;
    localparam logic [3:0] PLLCF_DLY_SET1 = 4'h6;
    localparam logic [3:0] PLLCF_DLY_SET2 = 4'ha;
    localparam logic [3:0] PLLCF_DLY_SET3 = 4'he;
    localparam logic [7:0] PLLCF_WAIT_CYC0 = 8'h01;
    localparam logic [7:0] PLLCF_WAIT_CYC1 = 8'h10;
    localparam logic [7:0] PLLCF_WAIT_CYC2 = 8'h40;
    localparam logic [7:0] PLLCF_WAIT_CYC3 = 8'h80;
    localparam logic [2:0] PLLCF_WIN_OFF = 3'h0;

    typedef enum logic [1:0] {
        PLLCF_WAIT_1 = 2'b00,
        PLLCF_WAIT_16 = 2'b01,
        PLLCF_WAIT_64 = 2'b10,
        PLLCF_WAIT_128 = 2'b11
    } pllcf_wait_t;
endpackage

// ---- rtl/pllcf_regs.sv ----
// Loop-filter and lock-detect configuration registers with decoded analog controls
`timescale 1ns/1ps
`default_nettype none
module pllcf_regs
    import pllcf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [PLLCF_AW-1:0] i_addr,
    input wire logic [PLLCF_DW-1:0] i_wdata,
    output logic [PLLCF_DW-1:0] o_rdata,
    output logic o_rd_ack,
    output logic [PLLCF_RES_W-1:0] o_zero_resistor_sel,
    output logic [PLLCF_PCAP_W-1:0] o_pole_capacitor_sel,
    output logic [PLLCF_DLY_W-1:0] o_pfd_reset_delay_sel,
    output logic [3:0] o_pfd_reset_delay,
    output logic [PLLCF_WIN_W-1:0] o_lockdet_window_sel,
    output logic o_lockdet_enable,
    output logic [7:0] o_lockdet_wait_cycles
);

    // Timer length in phase-detector cycles for a wait code
    function automatic logic [7:0] wait_cycles(input logic [1:0] code);
        logic [7:0] cyc;
        cyc = PLLCF_WAIT_CYC0;
        case (pllcf_wait_t'(code))
            PLLCF_WAIT_1: cyc = PLLCF_WAIT_CYC0;
            PLLCF_WAIT_16: cyc = PLLCF_WAIT_CYC1;
            PLLCF_WAIT_64: cyc = PLLCF_WAIT_CYC2;
            PLLCF_WAIT_128: cyc = PLLCF_WAIT_CYC3;
            default: cyc = PLLCF_WAIT_CYC0;
        endcase
        return cyc;
    endfunction

    // Reset delay setting for a delay code
    function automatic logic [3:0] delay_setting(input logic [1:0] code);
        logic [3:0] set;
        set = PLLCF_DLY_SET0;
        case (code)
            2'h0: set = PLLCF_DLY_SET0;
            2'h1: set = PLLCF_DLY_SET1;
            2'h2: set = PLLCF_DLY_SET2;
            2'h3: set = PLLCF_DLY_SET3;
            default: set = PLLCF_DLY_SET0;
        endcase
        return set;
    endfunction

    logic [15:0] loop_filter_q;
    logic [15:0] loop_filter_d;
    logic [15:0] lock_detect_q;
    logic [15:0] lock_detect_d;
    logic [15:0] rdata_d;
    wire sel_lf;
    wire sel_ld;

    // Address decode; other offsets are ignored on write and read as zero
    assign sel_lf = (i_addr == PLLCF_LOOP_FILTER_OFS);
    assign sel_ld = (i_addr == PLLCF_LOCK_DETECT_OFS);

    // Whole words are stored as written, so odd codes come back unchanged
    assign loop_filter_d = (i_wr_en && sel_lf) ? i_wdata : loop_filter_q;
    assign lock_detect_d = (i_wr_en && sel_ld) ? i_wdata : lock_detect_q;

    // Read mux sees the old value when a write hits the same edge
    assign rdata_d = sel_lf ? loop_filter_q : (sel_ld ? lock_detect_q : 16'h0000);

    // Storage with documented reset words
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            loop_filter_q <= PLLCF_LOOP_FILTER_RST;
            lock_detect_q <= PLLCF_LOCK_DETECT_RST;
        end else begin
            loop_filter_q <= loop_filter_d;
            lock_detect_q <= lock_detect_d;
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_rdata <= 16'h0000;
            o_rd_ack <= 1'b0;
        end else begin
            o_rd_ack <= i_rd_en;
            o_rdata <= i_rd_en ? rdata_d : o_rdata;
        end
    end

    // Analog controls are registered from the next word so they track storage exactly
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_zero_resistor_sel <= PLLCF_LOOP_FILTER_RST[PLLCF_RES_LSB +: PLLCF_RES_W];
            o_pole_capacitor_sel <= PLLCF_LOOP_FILTER_RST[PLLCF_PCAP_LSB +: PLLCF_PCAP_W];
            o_pfd_reset_delay_sel <= PLLCF_LOCK_DETECT_RST[PLLCF_DLY_LSB +: PLLCF_DLY_W];
            o_pfd_reset_delay <= PLLCF_DLY_SET0;
            o_lockdet_window_sel <= PLLCF_LOCK_DETECT_RST[PLLCF_WIN_LSB +: PLLCF_WIN_W];
            o_lockdet_enable <= 1'b1;
            o_lockdet_wait_cycles <= PLLCF_WAIT_CYC3;
        end else begin
            o_zero_resistor_sel <= loop_filter_d[PLLCF_RES_LSB +: PLLCF_RES_W];
            o_pole_capacitor_sel <= loop_filter_d[PLLCF_PCAP_LSB +: PLLCF_PCAP_W];
            o_pfd_reset_delay_sel <= lock_detect_d[PLLCF_DLY_LSB +: PLLCF_DLY_W];
            o_pfd_reset_delay <= delay_setting(lock_detect_d[PLLCF_DLY_LSB +: PLLCF_DLY_W]);
            o_lockdet_window_sel <= lock_detect_d[PLLCF_WIN_LSB +: PLLCF_WIN_W];
            // Code zero switches the comparator off rather than picking a tiny window
            o_lockdet_enable <= (lock_detect_d[PLLCF_WIN_LSB +: PLLCF_WIN_W] != PLLCF_WIN_OFF);
            o_lockdet_wait_cycles <= wait_cycles(lock_detect_d[PLLCF_WAIT_LSB +: PLLCF_WAIT_W]);
        end
    end

    // Checks on the register behaviour
    property p_ld_reset;
        @(posedge i_clk) $past(i_sys_rst) |-> lock_detect_q == 16'h0007;
    endproperty
    a_ld_reset: assert property (p_ld_reset) else $error("lock-detect reset word wrong");

    property p_ld_rsvd_store;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_wr_en && i_addr == 8'h21) |=> lock_detect_q[15:7] == $past(i_wdata[15:7]);
    endproperty
    a_ld_rsvd_store: assert property (p_ld_rsvd_store) else $error("reserved bits lost");

    property p_delay_map;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_pfd_reset_delay == {o_pfd_reset_delay_sel, 2'b10};
    endproperty
    a_delay_map: assert property (p_delay_map) else $error("reset delay decode wrong");

    property p_window_off;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_lockdet_enable == (o_lockdet_window_sel != 3'h0);
    endproperty
    a_window_off: assert property (p_window_off) else $error("lock enable mismatch");

    property p_wait_map;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_wr_en && i_addr == 8'h21 && i_wdata[1:0] == 2'h1) |=> o_lockdet_wait_cycles == 8'h10;
    endproperty
    a_wait_map: assert property (p_wait_map) else $error("wait length decode wrong");

    property p_res_follow;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_wr_en && i_addr == 8'h1f) |=> o_zero_resistor_sel == $past(i_wdata[8:5]);
    endproperty
    a_res_follow: assert property (p_res_follow) else $error("resistor select stale");

    property p_pcap_reset;
        @(posedge i_clk) $past(i_sys_rst) |-> o_pole_capacitor_sel == 5'h12;
    endproperty
    a_pcap_reset: assert property (p_pcap_reset) else $error("capacitor reset wrong");

    property p_lf_readback;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_wr_en && i_addr == 8'h1f) ##1 (i_rd_en && !i_wr_en && i_addr == 8'h1f)
        |=> o_rd_ack && o_rdata == $past(i_wdata, 2);
    endproperty
    a_lf_readback: assert property (p_lf_readback) else $error("loop-filter readback wrong");

    property p_unmapped_zero;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_rd_en && i_addr != 8'h1f && i_addr != 8'h21) |=> o_rdata == 16'h0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    // Acknowledge echoes the read strobe one cycle later, and stays high for as long as the strobe is held
    property p_rd_ack_pulse;
        @(posedge i_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) |-> o_rd_ack == $past(i_rd_en);
    endproperty
    a_rd_ack_pulse: assert property (p_rd_ack_pulse) else $error("read ack timing wrong");

    // Read data holds between reads, so a slow host may pick it up late
    property p_rdata_hold;
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_rd_en |=> $stable(o_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

    // Lock-detect fields reach the analog side on the edge after the write
    property p_ld_follow;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_wr_en && i_addr == 8'h21) |=> o_pfd_reset_delay_sel == $past(i_wdata[6:5])
            && o_lockdet_window_sel == $past(i_wdata[4:2]);
    endproperty
    a_ld_follow: assert property (p_ld_follow) else $error("lock-detect select stale");

    // Capacitor select follows the written word, odd codes included
    property p_pcap_follow;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_wr_en && i_addr == 8'h1f) |=> o_pole_capacitor_sel == $past(i_wdata[4:0]);
    endproperty
    a_pcap_follow: assert property (p_pcap_follow) else $error("capacitor select stale");

    // A write to a hole in the map must leave both words alone
    property p_stray_write;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_wr_en && i_addr != 8'h1f && i_addr != 8'h21)
        |=> $stable(loop_filter_q) && $stable(lock_detect_q);
    endproperty
    a_stray_write: assert property (p_stray_write) else $error("unmapped write changed a word");

    // Loop-filter word comes back to its reset value after every reset
    property p_lf_reset;
        @(posedge i_clk) $past(i_sys_rst) |-> loop_filter_q == 16'h1e72;
    endproperty
    a_lf_reset: assert property (p_lf_reset) else $error("loop-filter reset word wrong");

    // Decoded lock-detect controls start from the reset codes
    property p_ld_out_reset;
        @(posedge i_clk) $past(i_sys_rst) |-> o_lockdet_enable && o_pfd_reset_delay == 4'h2
            && o_lockdet_wait_cycles == 8'h80;
    endproperty
    a_ld_out_reset: assert property (p_ld_out_reset) else $error("decoded reset wrong");

    c_lf_write: cover property (@(posedge i_clk) i_wr_en && sel_lf);
    c_win_off: cover property (@(posedge i_clk) !o_lockdet_enable);
    c_wait_one: cover property (@(posedge i_clk) o_lockdet_wait_cycles == 8'd1);
    c_ld_read: cover property (@(posedge i_clk) i_rd_en && sel_ld);
    c_rd_after_wr: cover property (@(posedge i_clk) (i_wr_en && sel_lf) ##1 (i_rd_en && sel_lf));
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the loop-filter and lock-detect configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb
    import pllcf_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_wr_en = 1'b0;
    logic i_rd_en = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic [15:0] o_rdata, rv, v;
    logic o_rd_ack, en;
    logic [3:0] res, dly;
    logic [4:0] pcap;
    logic [1:0] dsel;
    logic [2:0] win;
    logic [7:0] wcyc;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [3:0] dly_tab [4] = '{4'h2, 4'h6, 4'ha, 4'he};
    logic [7:0] wait_tab [4] = '{8'h01, 8'h10, 8'h40, 8'h80};
    logic [15:0] lf_tab [3] = '{16'hffff, 16'h0194, 16'h0000};

    pllcf_regs dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .o_rd_ack(o_rd_ack), .o_zero_resistor_sel(res), .o_pole_capacitor_sel(pcap),
        .o_pfd_reset_delay_sel(dsel), .o_pfd_reset_delay(dly),
        .o_lockdet_window_sel(win), .o_lockdet_enable(en), .o_lockdet_wait_cycles(wcyc));

    // Free-running 20 MHz clock
    initial begin
        forever #25 i_clk = ~i_clk;
    end

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // An idle cycle leads each access so a strobe is never set twice in one step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge i_clk);
        i_wr_en = 1'b1;
        i_addr = a;
        i_wdata = d;
        @(negedge i_clk);
        i_wr_en = 1'b0;
    endtask

    // Answer lands on the taking edge and is picked up at the next falling edge
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge i_clk);
        i_rd_en = 1'b1;
        i_addr = a;
        @(negedge i_clk);
        i_rd_en = 1'b0;
        chk(16'(o_rd_ack), 16'h0001);
        d = o_rdata;
    endtask

    // Decoded lock-detect outputs against the rule tables
    task automatic chk_ld(input int d, input logic [2:0] w, input int t);
        chk(16'(dsel), 16'(d));
        chk(16'(dly), 16'(dly_tab[d]));
        chk(16'(win), 16'(w));
        chk(16'(en), 16'(w != 3'h0));
        chk(16'(wcyc), 16'(wait_tab[t]));
    endtask

    // Hang guard: the sequence needs a few hundred cycles at most
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        repeat (20) @(negedge i_clk);
        i_sys_rst = 1'b0;
        chk(16'(res), 16'h0003);
        chk(16'(pcap), 16'h0012);
        chk_ld(0, 3'h1, 3);
        rd(8'h1f, rv);
        chk(rv, 16'h1e72);
        rd(8'h21, rv);
        chk(rv, 16'h0007);
        // Every delay and wait code, window stepping through 0, 2, 4, 6
        for (int i = 0; i < 4; i++) begin
            v = 16'((i << 5) | ((2 * i) << 2) | i);
            wr(8'h21, v);
            chk_ld(i, 3'(2 * i), i);
            rd(8'h21, rv);
            chk(rv, v);
        end
        // Reserved bits held as storage, widest window
        wr(8'h21, 16'hff9e);
        chk_ld(0, 3'h7, 2);
        rd(8'h21, rv);
        chk(rv, 16'hff9e);
        // Out-of-range, top listed and zero codes kept as written
        for (int i = 0; i < 3; i++) begin
            wr(8'h1f, lf_tab[i]);
            chk(16'(res), 16'(lf_tab[i][8:5]));
            chk(16'(pcap), 16'(lf_tab[i][4:0]));
            rd(8'h1f, rv);
            chk(rv, lf_tab[i]);
        end
        // Unmapped offset between the two registers disturbs neither
        wr(8'h20, 16'hffff);
        rd(8'h20, rv);
        chk(rv, 16'h0000);
        rd(8'h21, rv);
        chk(rv, 16'hff9e);
        chk(16'(res), 16'h0000);
        // Read on the edge after a write, then a read that meets a write
        @(negedge i_clk);
        i_wr_en = 1'b1;
        i_addr = 8'h1f;
        i_wdata = 16'h1e72;
        @(negedge i_clk);
        i_wr_en = 1'b0;
        i_rd_en = 1'b1;
        @(negedge i_clk);
        i_wr_en = 1'b1;
        i_wdata = 16'h0155;
        chk(16'(o_rd_ack), 16'h0001);
        chk(o_rdata, 16'h1e72);
        @(negedge i_clk);
        i_wr_en = 1'b0;
        i_rd_en = 1'b0;
        chk(o_rdata, 16'h1e72);
        chk(16'(res), 16'h000a);
        chk(16'(pcap), 16'h0015);
        rd(8'h1f, rv);
        chk(rv, 16'h0155);
        // A second reset in mid-run brings back every reset word
        @(negedge i_clk);
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_sys_rst = 1'b0;
        chk(o_rdata, 16'h0000);
        chk(16'(o_rd_ack), 16'h0000);
        chk(16'(res), 16'h0003);
        chk(16'(pcap), 16'h0012);
        chk_ld(0, 3'h1, 3);
        rd(8'h1f, rv);
        chk(rv, 16'h1e72);
        rd(8'h21, rv);
        chk(rv, 16'h0007);
        test_done();
    end
endmodule
`default_nettype wire
